// >>> logic/lvdiv_regs.svh
// Purpose: register indices, field positions, reset values of the channel dividers
// Assumes: byte address is four times the register index
// Notes: register width 8, upper bus bits read zero
`ifndef LVDIV_REGS_SVH
`define LVDIV_REGS_SVH
`define LVDIV_IDX_DIV0_PERIOD 10'h190
`define LVDIV_IDX_DIV0_CTRL 10'h191
`define LVDIV_IDX_DIV0_ROUTE 10'h192
`define LVDIV_IDX_DIV1_PERIOD 10'h193
`define LVDIV_IDX_DIV1_CTRL 10'h194
`define LVDIV_IDX_SRC_SEL 10'h1E1
`define LVDIV_RST_DIV0_PERIOD 8'h00
`define LVDIV_RST_DIV0_CTRL 8'h80
`define LVDIV_RST_DIV0_ROUTE 8'h00
`define LVDIV_RST_DIV1_PERIOD 8'h00
`define LVDIV_RST_DIV1_CTRL 8'h00
`define LVDIV_RST_SRC_SEL 8'h00
`define LVDIV_BIT_DIRECT 1
`define LVDIV_BIT_DCC_OFF 0
`define LVDIV_SRC_OSC 2'h2
`define LVDIV_SRC_EXT 2'h0
`endif

// >>> logic/lvdiv_pkg.sv
// Purpose: types shared by the channel divider logic
// Assumes: nothing beyond the register header
// Notes: field order follows the register bit order, msb first
package lvdiv_pkg;
  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
  } lvdiv_period_t;
  typedef struct packed {
    logic bypass;
    logic nosync;
    logic force_high;
    logic start_high;
    logic [3:0] phase;
  } lvdiv_ctrl_t;
  typedef struct packed {
    logic level;
    logic [3:0] ph;
    logic [3:0] cnt;
  } lvdiv_state_t;
endpackage : lvdiv_pkg

// >>> logic/lvdiv_top.sv
// Purpose: two programmable channel dividers with Avalon-MM register access
// Assumes: divider input clocks far slower than clk; they are sampled here
// Notes: each divider advances once per rising edge of its sampled input
`timescale 1ns/1ps
`include "lvdiv_regs.svh"
module lvdiv_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic osc_clk_in,
  input wire logic ext_clk_in,
  input wire logic sync_n_in,
  output logic pair_a_output_first,
  output logic pair_a_output_second,
  output logic pair_b_output,
  output logic duty_correction_active
);

  if (ADDR_W < 12) begin : g_chk
    $error("lvdiv_top: ADDR_W must be at least 12");
  end

  // advance one divider by one clk cycle
  function automatic lvdiv_pkg::lvdiv_state_t lvdiv_step(
    input lvdiv_pkg::lvdiv_state_t s,
    input lvdiv_pkg::lvdiv_period_t p,
    input lvdiv_pkg::lvdiv_ctrl_t c,
    input logic edge_i,
    input logic sync_i
  );
    lvdiv_pkg::lvdiv_state_t n;
    n = s;
    if (c.bypass) begin
      // bypass: counters held cleared, source passed through to the output
      n.level = 1'b0;
      n.ph = 4'h0;
      n.cnt = 4'h0;
    end else if (sync_i && !c.nosync) begin
      n.level = c.start_high;
      n.ph = c.phase;
      n.cnt = c.start_high ? p.high : p.low;
    end else if (edge_i) begin
      if (s.ph != 4'h0) begin
        n.ph = s.ph - 4'h1;
      end else if (s.cnt != 4'h0) begin
        n.cnt = s.cnt - 4'h1;
      end else begin
        n.level = ~s.level;
        n.cnt = s.level ? p.low : p.high;
      end
    end
    return n;
  endfunction : lvdiv_step

  // output level of one divider before routing
  function automatic logic lvdiv_level(
    input lvdiv_pkg::lvdiv_state_t s,
    input lvdiv_pkg::lvdiv_ctrl_t c,
    input logic src_i
  );
    logic v;
    v = s.level;
    if (c.bypass) begin
      v = src_i;
    end else if (c.nosync) begin
      v = c.force_high;
    end
    return v;
  endfunction : lvdiv_level

  // registers
  logic [7:0] div0_period_q;
  logic [7:0] div0_control_q;
  logic [7:0] div0_output_route_q;
  logic [7:0] div1_period_q;
  logic [7:0] div1_control_q;
  logic [7:0] src_sel_q;

  // bus
  logic waitrequest_q;
  logic [31:0] readdata_q;

  // pin samplers
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic sync_s1_q;
  logic sync_s2_q;

  // divider state
  lvdiv_pkg::lvdiv_state_t div0_q;
  lvdiv_pkg::lvdiv_state_t div1_q;
  lvdiv_pkg::lvdiv_state_t div0_d;
  lvdiv_pkg::lvdiv_state_t div1_d;

  // outputs
  logic pair_a_first_q;
  logic pair_a_second_q;
  logic pair_b_q;
  logic dcc_active_q;

  // address decode
  wire logic [9:0] reg_idx = address[11:2];
  wire logic req = read | write;
  wire logic accept = req & ~waitrequest_q;
  wire logic wr_en = accept & write & byteenable[0];
  wire logic [7:0] wbyte = writedata[7:0];
  wire logic hit_p0 = reg_idx == `LVDIV_IDX_DIV0_PERIOD;
  wire logic hit_c0 = reg_idx == `LVDIV_IDX_DIV0_CTRL;
  wire logic hit_r0 = reg_idx == `LVDIV_IDX_DIV0_ROUTE;
  wire logic hit_p1 = reg_idx == `LVDIV_IDX_DIV1_PERIOD;
  wire logic hit_c1 = reg_idx == `LVDIV_IDX_DIV1_CTRL;
  wire logic hit_ss = reg_idx == `LVDIV_IDX_SRC_SEL;
  wire logic wr_p0 = wr_en & hit_p0;
  wire logic wr_c0 = wr_en & hit_c0;
  wire logic wr_r0 = wr_en & hit_r0;
  wire logic wr_p1 = wr_en & hit_p1;
  wire logic wr_c1 = wr_en & hit_c1;
  wire logic wr_ss = wr_en & hit_ss;
  wire logic [7:0] rd_byte =
    hit_p0 ? div0_period_q :
    hit_c0 ? div0_control_q :
    hit_r0 ? div0_output_route_q :
    hit_p1 ? div1_period_q :
    hit_c1 ? div1_control_q :
    hit_ss ? src_sel_q : 8'h00;

  // field views
  wire lvdiv_pkg::lvdiv_period_t per0 = lvdiv_pkg::lvdiv_period_t'(div0_period_q);
  wire lvdiv_pkg::lvdiv_period_t per1 = lvdiv_pkg::lvdiv_period_t'(div1_period_q);
  wire lvdiv_pkg::lvdiv_ctrl_t ctl0 = lvdiv_pkg::lvdiv_ctrl_t'(div0_control_q);
  wire lvdiv_pkg::lvdiv_ctrl_t ctl1 = lvdiv_pkg::lvdiv_ctrl_t'(div1_control_q);
  wire logic [1:0] src_sel = src_sel_q[1:0];
  wire logic direct = div0_output_route_q[`LVDIV_BIT_DIRECT];
  wire logic dcc_off = div0_output_route_q[`LVDIV_BIT_DCC_OFF];

  // divider input selection
  wire logic use_osc = src_sel == `LVDIV_SRC_OSC;
  wire logic src_lvl = use_osc ? osc_s2_q : ext_s2_q;
  wire logic osc_rise = osc_s2_q & ~osc_s3_q;
  wire logic ext_rise = ext_s2_q & ~ext_s3_q;
  wire logic src_rise = use_osc ? osc_rise : ext_rise;
  wire logic sync_act = ~sync_s2_q;

  assign div0_d = lvdiv_step(div0_q, per0, ctl0, src_rise, sync_act);
  assign div1_d = lvdiv_step(div1_q, per1, ctl1, src_rise, sync_act);

  wire logic div0_lvl = lvdiv_level(div0_q, ctl0, src_lvl);
  wire logic div1_lvl = lvdiv_level(div1_q, ctl1, src_lvl);

  // first pair routing
  wire logic route_osc = direct && (src_sel == `LVDIV_SRC_OSC);
  wire logic route_ext = direct && (src_sel == `LVDIV_SRC_EXT);
  wire logic pair_a_d =
    route_osc ? osc_s2_q :
    route_ext ? ext_s2_q : div0_lvl;

  // bus slave: one wait cycle, answer on the second edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      waitrequest_q <= ~(req & waitrequest_q);
      if (read & waitrequest_q) begin
        readdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div0_period_q <= `LVDIV_RST_DIV0_PERIOD;
    end else if (wr_p0) begin
      div0_period_q <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div0_control_q <= `LVDIV_RST_DIV0_CTRL;
    end else if (wr_c0) begin
      div0_control_q <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div0_output_route_q <= `LVDIV_RST_DIV0_ROUTE;
    end else if (wr_r0) begin
      div0_output_route_q <= {6'h00, wbyte[1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div1_period_q <= `LVDIV_RST_DIV1_PERIOD;
    end else if (wr_p1) begin
      div1_period_q <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div1_control_q <= `LVDIV_RST_DIV1_CTRL;
    end else if (wr_c1) begin
      div1_control_q <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      src_sel_q <= `LVDIV_RST_SRC_SEL;
    end else if (wr_ss) begin
      src_sel_q <= {6'h00, wbyte[1:0]};
    end
  end

  // two-flop samplers, third stage only for edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // resync pin idles high, so reset to its idle level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
    end else begin
      sync_s1_q <= sync_n_in;
      sync_s2_q <= sync_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div0_q <= '0;
    end else begin
      div0_q <= div0_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div1_q <= '0;
    end else begin
      div1_q <= div1_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pair_a_first_q <= 1'b0;
      pair_a_second_q <= 1'b0;
      pair_b_q <= 1'b0;
    end else begin
      pair_a_first_q <= pair_a_d;
      pair_a_second_q <= pair_a_d;
      pair_b_q <= div1_lvl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dcc_active_q <= 1'b1;
    end else begin
      dcc_active_q <= ~dcc_off;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign pair_a_output_first = pair_a_first_q;
  assign pair_a_output_second = pair_a_second_q;
  assign pair_b_output = pair_b_q;
  assign duty_correction_active = dcc_active_q;

endmodule : lvdiv_top

// >>> verif/lvdiv_checker.sv
// Purpose: port assertions for lvdiv_top
// Assumes: one wait cycle per bus request
// Notes: bound to every lvdiv_top
`timescale 1ns/1ps
module lvdiv_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic osc_clk_in,
  input wire logic ext_clk_in,
  input wire logic sync_n_in,
  input wire logic pair_a_output_first,
  input wire logic pair_a_output_second,
  input wire logic pair_b_output,
  input wire logic duty_correction_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence quiet;
    $stable(osc_clk_in) && $stable(ext_clk_in) && $stable(sync_n_in) && !write;
  endsequence
  a_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  a_wait_idle: assert property (!read && !write |-> waitrequest)
    else $error("answer without request");
  a_wait_cause: assert property (!waitrequest |-> ($past(read) || $past(write)) && (read || write))
    else $error("answer without held request");
  a_rdata_upper: assert property (readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pair_legs: assert property (pair_a_output_first == pair_a_output_second)
    else $error("pair legs differ");
  a_dcc_hold: assert property (!$past(write) && !$past(write, 2) && !$past(write, 3)
    |-> $stable(duty_correction_active)) else $error("duty flag moved");
  a_out_quiet: assert property (quiet [*6] |-> $stable(pair_a_output_first)
    && $stable(pair_b_output)) else $error("output moved without cause");
  cover property (write && !waitrequest);
  cover property (read && !waitrequest);
  cover property ($rose(pair_b_output));
  cover property (quiet [*6]);
endmodule : lvdiv_checker
bind lvdiv_top lvdiv_checker chk_u (.clk(clk), .rstn(rstn), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .osc_clk_in(osc_clk_in),
  .ext_clk_in(ext_clk_in), .sync_n_in(sync_n_in), .pair_a_output_first(pair_a_output_first),
  .pair_a_output_second(pair_a_output_second), .pair_b_output(pair_b_output),
  .duty_correction_active(duty_correction_active));

// >>> verif/lvpecl_channel_divider_tb.sv
// Purpose: self-checking bench for lvdiv_top
// Assumes: sources clk-synchronous, ext period 6 clk, osc period 10 clk
// Notes: read results checked by a monitor from a queue
`timescale 1ns/1ps
module lvpecl_channel_divider_tb;
  logic clk, rstn, read, write, osc_clk_in, ext_clk_in, sync_n_in, waitrequest, pa, pb, dcc;
  logic [11:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [1:0] h, l;
  logic src_run;
  logic [31:0] q[$];
  int mismatches, n_checks, hi, lo, seed;
  lvdiv_top dut_u (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .osc_clk_in(osc_clk_in), .ext_clk_in(ext_clk_in),
    .sync_n_in(sync_n_in), .pair_a_output_first(pa), .pair_a_output_second(),
    .pair_b_output(pb), .duty_correction_active(dcc));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always begin
    repeat (3) @(posedge clk);
    if (src_run) ext_clk_in <= ~ext_clk_in;
  end
  always begin
    repeat (5) @(posedge clk);
    if (src_run) osc_clk_in <= ~osc_clk_in;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic bus(input logic rw, input logic [9:0] i, input logic [7:0] d);
    address <= {i, 2'h0};
    writedata <= {24'h0, d};
    read <= !rw;
    write <= rw;
    @(posedge clk);
    while (waitrequest !== 1'h0) @(posedge clk);
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(1'h0, i, 8'h00);
  endtask : rd
  function automatic logic o(input logic b);
    return b ? pb : pa;
  endfunction : o
  task automatic meas(input logic b, input int eh, input int el);
    repeat (60) @(posedge clk);
    while (o(b) !== 1'h0) @(posedge clk);
    while (o(b) !== 1'h1) @(posedge clk);
    hi = 0;
    lo = 0;
    while (o(b) === 1'h1) begin
      @(posedge clk);
      hi++;
    end
    while (o(b) === 1'h0) begin
      @(posedge clk);
      lo++;
    end
    chk("high time", hi, eh);
    chk("low time", lo, el);
  endtask : meas
  always @(posedge clk) if (read === 1'h1 && waitrequest === 1'h0)
    chk("readdata", readdata, q.pop_front());
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    rstn = 1'h0; read = 1'h0; write = 1'h0; address = 12'h0; writedata = 32'h0;
    byteenable = 4'hF; osc_clk_in = 1'h0; ext_clk_in = 1'h0; sync_n_in = 1'h1;
    seed = 32'h6424;
    src_run = 1'h1;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(10'h190, 8'h00);
    rd(10'h191, 8'h80);
    rd(10'h192, 8'h00);
    rd(10'h193, 8'h00);
    rd(10'h194, 8'h00);
    rd(10'h100, 8'h00);
    chk("duty flag", dcc, 1'h1);
    meas(1'h0, 3, 3);
    meas(1'h1, 6, 6);
    bus(1'h1, 10'h191, 8'h00);
    bus(1'h1, 10'h190, 8'h10);
    meas(1'h0, 6, 12);
    byteenable <= 4'hE;
    bus(1'h1, 10'h190, 8'hFF);
    byteenable <= 4'hF;
    rd(10'h190, 8'h10);
    repeat (6) begin
      h = 2'($random(seed));
      l = 2'($random(seed));
      bus(1'h1, 10'h193, {2'h0, l, 2'h0, h});
      meas(1'h1, (h + 1) * 6, (l + 1) * 6);
      rd(10'h193, {2'h0, l, 2'h0, h});
    end
    bus(1'h1, 10'h191, 8'h60);
    repeat (20) @(posedge clk);
    chk("forced high", pa, 1'h1);
    bus(1'h1, 10'h191, 8'h40);
    repeat (20) @(posedge clk);
    chk("forced low", pa, 1'h0);
    bus(1'h1, 10'h193, 8'h00);
    bus(1'h1, 10'h194, 8'h10);
    sync_n_in <= 1'h0;
    repeat (20) @(posedge clk);
    chk("held start", pb, 1'h1);
    bus(1'h1, 10'h194, 8'h50);
    repeat (20) @(posedge clk);
    chk("sync ignored", pb, 1'h0);
    bus(1'h1, 10'h194, 8'h00);
    sync_n_in <= 1'h1;
    meas(1'h1, 6, 6);
    bus(1'h1, 10'h192, 8'h02);
    meas(1'h0, 3, 3);
    bus(1'h1, 10'h1E1, 8'h02);
    meas(1'h0, 5, 5);
    bus(1'h1, 10'h1E1, 8'h01);
    repeat (20) @(posedge clk);
    chk("no effect", pa, 1'h0);
    src_run <= 1'h0;
    repeat (30) @(posedge clk);
    chk("stopped source", pa, 1'h0);
    src_run <= 1'h1;
    bus(1'h1, 10'h192, 8'h01);
    repeat (5) @(posedge clk);
    chk("duty flag", dcc, 1'h0);
    rd(10'h192, 8'h01);
    results();
  end
endmodule : lvpecl_channel_divider_tb
